// file: core/dpct_pkg.sv
// Package: register map, field layouts, codes and reset values of the dual pulse counter/timer
package dpct_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned DPCT_ADDR_W = 8;
  localparam int unsigned DPCT_IDX_W = 6;

  // ---------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] DPCT_IDX_BYTE_CTRL = 6'h00;
  localparam logic [5:0] DPCT_IDX_SHARED_CTRL = 6'h01;
  localparam logic [5:0] DPCT_IDX_WORD_CTRL = 6'h02;
  localparam logic [5:0] DPCT_IDX_BYTE_LOW = 6'h04;
  localparam logic [5:0] DPCT_IDX_BYTE_HIGH = 6'h05;
  localparam logic [5:0] DPCT_IDX_WORD_LOWER = 6'h06;
  localparam logic [5:0] DPCT_IDX_WORD_UPPER = 6'h07;
  localparam logic [5:0] DPCT_IDX_WCAP_LOWER = 6'h08;
  localparam logic [5:0] DPCT_IDX_WCAP_UPPER = 6'h09;
  localparam logic [5:0] DPCT_IDX_BCAP = 6'h0A;
  localparam logic [5:0] DPCT_IDX_PORT = 6'h0C;
  localparam logic [5:0] DPCT_IDX_CAP_STAT = 6'h0D;

  // ---------------------------------------------------------------
  // Field positions of the capture status register (write 1 clears)
  // ---------------------------------------------------------------
  localparam int unsigned DPCT_CAP_BYTE_BIT = 0;
  localparam int unsigned DPCT_CAP_WORD_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and recovery-reset keep masks
  // ---------------------------------------------------------------
  localparam logic [7:0] DPCT_CTRL_RESET = 8'h00;
  localparam logic [7:0] DPCT_COUNT_RESET = 8'h00;
  localparam logic [7:0] DPCT_KEEP_BYTE = 8'h3E;
  localparam logic [7:0] DPCT_KEEP_WORD = 8'h3C;
  localparam logic [7:0] DPCT_KEEP_SHARED = 8'h30;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DPCT_DIV1 = 2'h0;
  localparam logic [1:0] DPCT_DIV2 = 2'h1;
  localparam logic [1:0] DPCT_DIV4 = 2'h2;
  localparam logic [1:0] DPCT_MODE_TRANSMIT = 2'h0;
  localparam logic [1:0] DPCT_MODE_PINGPONG = 2'h1;
  localparam logic [1:0] DPCT_MODE_DEMOD = 2'h2;
  localparam logic [1:0] DPCT_EDGE_FALL = 2'h0;
  localparam logic [1:0] DPCT_EDGE_RISE = 2'h1;
  localparam logic [1:0] DPCT_RESP_OKAY = 2'h0;
  localparam logic [1:0] DPCT_RESP_SLVERR = 2'h2;
  localparam logic [7:0] DPCT_BYTE_LAST = 8'h01;
  localparam logic [15:0] DPCT_WORD_LAST = 16'h0001;
  localparam logic [15:0] DPCT_WORD_WRAP = 16'hFFFF;

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       run;
    logic       single;
    logic       timeout;
    logic [1:0] clk_sel;
    logic       cap_ie;
    logic       to_ie;
    logic       route;
  } dpct_tctrl_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] edge_sel;
    logic [1:0] mode;
    logic       byte_init;
    logic       word_init;
  } dpct_shared_t;

endpackage

// file: core/dpct_prescaler.sv
// Module: system clock divider that issues count ticks at /1, /2, /4 or /8
module dpct_prescaler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] div_sel,
  // Tick
  output logic tick
);
  import dpct_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] mask;

  // Phase counter; held at zero while stopped so the first period is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Divider select
  always_comb begin
    case (div_sel)
      DPCT_DIV1: mask = 3'h0;
      DPCT_DIV2: mask = 3'h1;
      DPCT_DIV4: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  assign tick = run && ((cnt_q & mask) == mask);

endmodule

// file: core/dpct_edge_detect.sv
// Module: pin synchroniser and selectable edge detector for the demodulation input
module dpct_edge_detect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and selection
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Detected edge
  output logic edge_seen
);
  import dpct_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;

  // Two-stage synchroniser, then one more stage for edge compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edge polarity select
  assign rise = sync2_q && !prev_q;
  assign fall = !sync2_q && prev_q;
  always_comb begin
    case (edge_sel)
      DPCT_EDGE_FALL: edge_seen = fall;
      DPCT_EDGE_RISE: edge_seen = rise;
      default: edge_seen = rise || fall;
    endcase
  end

endmodule

// file: core/dpct_top.sv
// Module: dual pulse counter/timer with AXI4-Lite register access
//
// The AXI4-Lite register port is this design's own decision.
module dpct_top #(
  parameter int unsigned ADDR_W = dpct_pkg::DPCT_ADDR_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stop-mode recovery reset, same clock, active high
  input wire logic recovery_reset,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic demod_in,
  output logic byte_output_pin,
  output logic word_output_pin,
  // Interrupt requests
  output logic byte_timeout_irq,
  output logic byte_capture_irq,
  output logic word_timeout_irq,
  output logic word_capture_irq
);
  import dpct_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  dpct_tctrl_t bctrl_q;
  dpct_tctrl_t wctrl_q;
  dpct_shared_t shared_q;
  logic [7:0] byte_low_time_count_q;
  logic [7:0] byte_high_time_count_q;
  logic [7:0] word_count_lower_q;
  logic [7:0] word_count_upper_q;
  logic [7:0] bcnt_q;
  logic [15:0] wcnt_q;
  logic [15:0] wcap_q;
  logic [7:0] bcap_q;
  logic [1:0] cap_flag_q;
  logic [1:0] port_q;
  logic byte_timer_output_q;
  logic word_timer_output_q;
  logic armed_q;
  logic aw_have_q;
  logic w_have_q;
  logic [DPCT_IDX_W-1:0] aw_idx_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic wr_en;
  logic [DPCT_IDX_W-1:0] ar_idx;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic wr_bctrl;
  logic wr_wctrl;
  logic wr_shared;
  logic b_tick;
  logic w_tick;
  logic edge_seen;
  logic pingpong;
  logic demod;
  logic b_start;
  logic b_term;
  logic w_start;
  logic w_term;
  logic w_wrap;
  logic w_edge_take;
  logic w_to_capture;
  logic pp_to_word;
  logic pp_to_byte;

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  dpct_prescaler u_byte_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(bctrl_q.run),
    .div_sel(bctrl_q.clk_sel),
    .tick(b_tick)
  );

  dpct_prescaler u_word_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(wctrl_q.run),
    .div_sel(wctrl_q.clk_sel),
    .tick(w_tick)
  );

  dpct_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(demod_in),
    .edge_sel(shared_q.edge_sel),
    .edge_seen(edge_seen)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  // Address and data are taken independently; one write in flight at a time
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_en = aw_have_q && w_have_q && !bvalid_q && wstrb0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= DPCT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? DPCT_RESP_OKAY : DPCT_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write decode
  always_comb begin
    case (aw_idx_q)
      DPCT_IDX_BYTE_CTRL, DPCT_IDX_SHARED_CTRL, DPCT_IDX_WORD_CTRL, DPCT_IDX_BYTE_LOW,
      DPCT_IDX_BYTE_HIGH, DPCT_IDX_WORD_LOWER, DPCT_IDX_WORD_UPPER, DPCT_IDX_PORT,
      DPCT_IDX_CAP_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  assign wr_bctrl = wr_en && (aw_idx_q == DPCT_IDX_BYTE_CTRL);
  assign wr_wctrl = wr_en && (aw_idx_q == DPCT_IDX_WORD_CTRL);
  assign wr_shared = wr_en && (aw_idx_q == DPCT_IDX_SHARED_CTRL);

  // Read mux; status fields show live timer state
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      DPCT_IDX_BYTE_CTRL: rd_byte = bctrl_q;
      DPCT_IDX_SHARED_CTRL: rd_byte = shared_q;
      DPCT_IDX_WORD_CTRL: rd_byte = wctrl_q;
      DPCT_IDX_BYTE_LOW: rd_byte = byte_low_time_count_q;
      DPCT_IDX_BYTE_HIGH: rd_byte = byte_high_time_count_q;
      DPCT_IDX_WORD_LOWER: rd_byte = word_count_lower_q;
      DPCT_IDX_WORD_UPPER: rd_byte = word_count_upper_q;
      DPCT_IDX_WCAP_LOWER: rd_byte = wcap_q[7:0];
      DPCT_IDX_WCAP_UPPER: rd_byte = wcap_q[15:8];
      DPCT_IDX_BCAP: rd_byte = bcap_q;
      DPCT_IDX_PORT: rd_byte = {6'h00, port_q};
      DPCT_IDX_CAP_STAT: rd_byte = {6'h00, cap_flag_q};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= DPCT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? DPCT_RESP_OKAY : DPCT_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---------------------------------------------------------------
  // Timer events
  // ---------------------------------------------------------------
  assign pingpong = (shared_q.mode == DPCT_MODE_PINGPONG);
  assign demod = (shared_q.mode == DPCT_MODE_DEMOD);
  // A loaded 0 is not terminal: it runs 0, FF, ... down to 1 first
  assign b_term = bctrl_q.run && b_tick && (bcnt_q == DPCT_BYTE_LAST);
  assign w_term = !demod && wctrl_q.run && w_tick && (wcnt_q == DPCT_WORD_LAST);
  assign w_wrap = demod && wctrl_q.run && w_tick && (wcnt_q == 16'h0000);
  assign pp_to_word = pingpong && b_term;
  assign pp_to_byte = pingpong && w_term;
  assign b_start = (wr_bctrl && wdata_q[7] && !bctrl_q.run) || pp_to_byte;
  assign w_start = (wr_wctrl && wdata_q[7] && !wctrl_q.run) || pp_to_word;
  // Edges count only while armed or while bit 6 is clear
  assign w_edge_take = demod && wctrl_q.run && edge_seen && (!wctrl_q.single || armed_q);
  assign w_to_capture = demod && wctrl_q.run && wctrl_q.single && b_term;

  // ---------------------------------------------------------------
  // Byte timer control register
  // ---------------------------------------------------------------
  // Hardware set of timeout wins over a simultaneous software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bctrl_q <= DPCT_CTRL_RESET;
    end else if (recovery_reset) begin
      bctrl_q <= bctrl_q & DPCT_KEEP_BYTE;
    end else begin
      if (wr_bctrl) begin
        bctrl_q.run <= wdata_q[7];
        bctrl_q.single <= wdata_q[6];
        bctrl_q.clk_sel <= wdata_q[4:3];
        bctrl_q.cap_ie <= wdata_q[2];
        bctrl_q.to_ie <= wdata_q[1];
        bctrl_q.route <= wdata_q[0];
        bctrl_q.timeout <= (bctrl_q.timeout && !wdata_q[5]) || b_term;
      end else if (b_term) begin
        bctrl_q.timeout <= 1'b1;
      end
      if (pp_to_byte) begin
        bctrl_q.run <= 1'b1;
      end else if (b_term && (bctrl_q.single || pingpong)) begin
        bctrl_q.run <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Word timer control register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wctrl_q <= DPCT_CTRL_RESET;
    end else if (recovery_reset) begin
      wctrl_q <= wctrl_q & DPCT_KEEP_WORD;
    end else begin
      if (wr_wctrl) begin
        wctrl_q.run <= wdata_q[7];
        wctrl_q.single <= wdata_q[6];
        wctrl_q.clk_sel <= wdata_q[4:3];
        wctrl_q.cap_ie <= wdata_q[2];
        wctrl_q.to_ie <= wdata_q[1];
        wctrl_q.route <= wdata_q[0];
        wctrl_q.timeout <= (wctrl_q.timeout && !wdata_q[5]) || w_term || w_wrap;
      end else if (w_term || w_wrap) begin
        wctrl_q.timeout <= 1'b1;
      end
      if (pp_to_word) begin
        wctrl_q.run <= 1'b1;
      end else if (w_term && (wctrl_q.single || pingpong)) begin
        wctrl_q.run <= 1'b0;
      end
    end
  end

  // Arm after bit 6 goes 0 to 1; one accepted edge disarms
  always_ff @(posedge aclk) begin
    if (!aresetn || recovery_reset) begin
      armed_q <= 1'b0;
    end else if (wr_wctrl && wdata_q[6] && !wctrl_q.single) begin
      armed_q <= 1'b1;
    end else if (w_edge_take || (wr_wctrl && !wdata_q[6])) begin
      armed_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Shared control, count and port data registers
  // ---------------------------------------------------------------
  // Count registers feed the counters only at a load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_q <= DPCT_CTRL_RESET;
      byte_low_time_count_q <= DPCT_COUNT_RESET;
      byte_high_time_count_q <= DPCT_COUNT_RESET;
      word_count_lower_q <= DPCT_COUNT_RESET;
      word_count_upper_q <= DPCT_COUNT_RESET;
      port_q <= 2'h0;
    end else if (recovery_reset) begin
      shared_q <= shared_q & DPCT_KEEP_SHARED;
    end else if (wr_en) begin
      if (wr_shared) begin
        shared_q <= wdata_q;
      end
      if (aw_idx_q == DPCT_IDX_BYTE_LOW) begin
        byte_low_time_count_q <= wdata_q;
      end
      if (aw_idx_q == DPCT_IDX_BYTE_HIGH) begin
        byte_high_time_count_q <= wdata_q;
      end
      if (aw_idx_q == DPCT_IDX_WORD_LOWER) begin
        word_count_lower_q <= wdata_q;
      end
      if (aw_idx_q == DPCT_IDX_WORD_UPPER) begin
        word_count_upper_q <= wdata_q;
      end
      if (aw_idx_q == DPCT_IDX_PORT) begin
        port_q <= wdata_q[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Byte timer counter and output
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_q <= DPCT_COUNT_RESET;
      byte_timer_output_q <= 1'b0;
    end else if (b_start) begin
      byte_timer_output_q <= shared_q.byte_init;
      bcnt_q <= shared_q.byte_init ? byte_high_time_count_q : byte_low_time_count_q;
    end else if (b_term) begin
      byte_timer_output_q <= !byte_timer_output_q;
      if (bctrl_q.single || pingpong) begin
        bcnt_q <= 8'h00;
      end else begin
        // Reload by the level just toggled to
        bcnt_q <= byte_timer_output_q ? byte_low_time_count_q : byte_high_time_count_q;
      end
    end else if (bctrl_q.run && b_tick) begin
      bcnt_q <= bcnt_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Word timer counter and output
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_q <= 16'h0000;
      word_timer_output_q <= 1'b0;
    end else if (w_start) begin
      word_timer_output_q <= shared_q.word_init;
      wcnt_q <= {word_count_upper_q, word_count_lower_q};
    end else if (w_edge_take) begin
      wcnt_q <= {word_count_upper_q, word_count_lower_q};
    end else if (w_term) begin
      word_timer_output_q <= !word_timer_output_q;
      if (wctrl_q.single || pingpong) begin
        wcnt_q <= 16'h0000;
      end else begin
        wcnt_q <= {word_count_upper_q, word_count_lower_q};
      end
    end else if (w_wrap) begin
      wcnt_q <= DPCT_WORD_WRAP;
    end else if (wctrl_q.run && w_tick) begin
      wcnt_q <= wcnt_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Capture registers and flags
  // ---------------------------------------------------------------
  // Capture flag set wins over a write-1 clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcap_q <= 16'h0000;
      bcap_q <= 8'h00;
      cap_flag_q <= 2'h0;
    end else begin
      if (w_edge_take || w_to_capture) begin
        wcap_q <= wcnt_q;
      end
      if (w_edge_take) begin
        bcap_q <= bcnt_q;
      end
      cap_flag_q[DPCT_CAP_BYTE_BIT] <= (cap_flag_q[DPCT_CAP_BYTE_BIT] &&
        !(wr_en && aw_idx_q == DPCT_IDX_CAP_STAT && wdata_q[DPCT_CAP_BYTE_BIT])) ||
        w_edge_take;
      cap_flag_q[DPCT_CAP_WORD_BIT] <= (cap_flag_q[DPCT_CAP_WORD_BIT] &&
        !(wr_en && aw_idx_q == DPCT_IDX_CAP_STAT && wdata_q[DPCT_CAP_WORD_BIT])) ||
        w_edge_take || w_to_capture;
    end
  end

  // ---------------------------------------------------------------
  // Pins and interrupt requests
  // ---------------------------------------------------------------
  // Registered so the pins never glitch on a mux change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_output_pin <= 1'b0;
      word_output_pin <= 1'b0;
      byte_timeout_irq <= 1'b0;
      byte_capture_irq <= 1'b0;
      word_timeout_irq <= 1'b0;
      word_capture_irq <= 1'b0;
    end else begin
      byte_output_pin <= bctrl_q.route ? byte_timer_output_q : port_q[0];
      word_output_pin <= wctrl_q.route ? word_timer_output_q : port_q[1];
      byte_timeout_irq <= bctrl_q.timeout && bctrl_q.to_ie;
      byte_capture_irq <= cap_flag_q[DPCT_CAP_BYTE_BIT] && bctrl_q.cap_ie;
      word_timeout_irq <= wctrl_q.timeout && wctrl_q.to_ie;
      word_capture_irq <= cap_flag_q[DPCT_CAP_WORD_BIT] && wctrl_q.cap_ie;
    end
  end

endmodule

// file: dv/dpct_assertions.sv
// Checker: port-level bus and timing assertions for the counter/timer top
module dpct_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken, reads keep their data meanwhile
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer changed early");
  property p_arrdy; s_axi_arready == !s_axi_rvalid; endproperty
  a_arrdy: assert property (p_arrdy) else $error("arready not inverse of rvalid");
  property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wblk: assert property (p_wblk) else $error("write taken during response");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer off by cycles");
  property p_rpad; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rpad: assert property (p_rpad) else $error("upper read bits not zero");
  property p_rerr; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_rerr: assert property (p_rerr) else $error("error read carries data");
  // Main traffic seen
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind dpct_top dpct_assertions u_dpct_assertions (.*);

// file: dv/dpct_carrier.sv
// Partner: carrier source that toggles the demodulation pin within bursts
module dpct_carrier (
  input wire logic aclk,
  input wire logic active,
  output logic demod_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int n = 0;
  initial demod_in = 1'b0;
  // Level holds between bursts, so no stray edge reaches the timer
  always @(posedge aclk) begin
    n <= (n == 8) ? 0 : n + 1;
    if (active && n == 8) demod_in <= !demod_in;
  end
endmodule

// file: dv/dual_pulse_counter_timer_bench.sv
// Testbench: register-level checks of the dual pulse counter/timer
module dual_pulse_counter_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 0, aresetn = 0, recovery_reset = 0, active = 0, demod_in;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, cv;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, byte_output_pin, word_output_pin;
  logic byte_timeout_irq, byte_capture_irq, word_timeout_irq, word_capture_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int err_count = 0, tests_run = 0, cyc = 0, n, dv, t;
  int seed = 32'hdd7ed8a5;
  dpct_top u_dpct_top (.*);
  dpct_carrier u_dpct_carrier (.aclk(aclk), .active(active), .demod_in(demod_in));
  initial forever #2 aclk = ~aclk;
  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [5:0] i, input logic [7:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [5:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the several hundred cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin err_count++; complete_run; end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(6'h00); chk("byte ctrl", 0, rv);
    rd(6'h03); chk("unmapped resp", 2, rr);
    chk("unmapped data", 0, rv);
    $display("reset test done");
    wr(6'h01, 8'h00);
    // Single pass at every divider; model time is count times divisor
    for (dv = 0; dv < 4; dv++) begin
      n = 4 + ($random(seed) & 7);
      t = n * (1 << dv);
      cv = 8'h43 | 8'(dv << 3);
      wr(6'h04, 8'(n));
      wr(6'h00, cv | 8'h80);
      repeat (t / 2) @(posedge aclk);
      chk("pin mid", 0, byte_output_pin);
      repeat (t + 12) @(posedge aclk);
      chk("pin end", 1, byte_output_pin);
      chk("timeout irq", 1, byte_timeout_irq);
      rd(6'h00); chk("ctrl done", cv | 8'h20, rv);
      wr(6'h00, cv | 8'h20); rd(6'h00); chk("ctrl clear", cv, rv);
      chk("irq clear", 0, byte_timeout_irq);
    end
    $display("byte timer test done");
    wr(6'h00, 8'h47);
    @(posedge aclk) recovery_reset <= 1;
    @(posedge aclk) recovery_reset <= 0;
    rd(6'h00); chk("kept masks", 8'h06, rv);
    $display("recovery test done");
    wr(6'h06, 8'h05); wr(6'h07, 8'h00); wr(6'h02, 8'h83);
    repeat (30) @(posedge aclk);
    rd(6'h02); chk("word reload", 8'hA3, rv);
    chk("word irq", 1, word_timeout_irq);
    wr(6'h02, 8'h00); wr(6'h02, 8'h20);
    rd(6'h02); chk("word stop", 0, rv);
    // Both routes are off now, so the pins follow the port data bits
    wr(6'h0C, 8'h03);
    @(posedge aclk);
    chk("port pins", 3, {word_output_pin, byte_output_pin});
    $display("word timer test done");
    wr(6'h01, 8'h28); wr(6'h02, 8'h80); wr(6'h02, 8'hC4);
    active <= 1;
    repeat (60) @(posedge aclk);
    active <= 0;
    rd(6'h0D); chk("word capture", 2, rv & 2);
    chk("word cap irq", 1, word_capture_irq);
    chk("byte cap irq", 1, byte_capture_irq);
    $display("demodulation test done");
    // Quiet both timers and flags before chaining them
    wr(6'h02, 8'h20); wr(6'h00, 8'h20); wr(6'h0D, 8'h03);
    wr(6'h01, 8'h04); wr(6'h04, 8'h06); wr(6'h02, 8'h43);
    wr(6'h00, 8'hC3);
    repeat (40) @(posedge aclk);
    rd(6'h02); chk("pp word timeout", 8'h20, rv & 8'h20);
    chk("pp word irq", 1, word_timeout_irq);
    wr(6'h01, 8'h00);
    repeat (30) @(posedge aclk);
    // Reads 3 cycles apart; a live chain would show the byte run bit in one
    cv = 8'h00;
    repeat (4) begin
      rd(6'h00);
      cv = cv | rv[7:0];
    end
    chk("pp stopped", 0, cv & 8'h80);
    $display("ping-pong test done");
    complete_run;
  end
endmodule
